// File: src/pattern_irq_regs_defs.svh
// Register offsets, field positions and reset values of the pattern and interrupt register bank
`ifndef PATTERN_IRQ_REGS_DEFS_SVH
`define PATTERN_IRQ_REGS_DEFS_SVH
`define OFS_GENERAL_CONFIG     8'h04
`define OFS_PATTERN_CONTROL    8'h64
`define OFS_PATTERN_CONFIG     8'h65
`define OFS_PATTERN_IND_ADDR   8'h66
`define OFS_PATTERN_IND_DATA   8'h67
`define OFS_INTERRUPT_CONTROL  8'hC6
`define OFS_INTERRUPT_STATUS   8'hC7
`define BIT_BLANK_SUPPRESS     1
`define BIT_PATTERN_ENABLE     0
`define BIT_TIMING_SELECT      2
`define BIT_COLOR_INVERT       1
`define BIT_AUTO_SCROLL        0
`define BIT_DOWNSTREAM_IRQ     5
`define BIT_GLOBAL_IRQ         0
`define MASK_INTERRUPT         8'h21
`define RST_GENERAL_CONFIG     8'h00
`define RST_PATTERN_CONTROL    8'h10
`define RST_PATTERN_CONFIG     8'h00
`define RST_PATTERN_IND_ADDR   8'h00
`define RST_INTERRUPT_CONTROL  8'h00
`define RST_INDIRECT_BYTE      8'h00
`endif

// File: src/pattern_irq_regs_pkg.sv
// Types of the pattern and interrupt register bank
package pattern_irq_regs_pkg;
  typedef enum logic [1:0] {
    IDLE,
    WRITE_IND,
    READ_DONE
  } phase_t;

  typedef struct packed {
    logic [7:0]   generalConfig;
    logic [7:0]   patternControl;
    logic [7:0]   patternConfig;
    logic [7:0]   indirectAddress;
    logic [7:0]   interruptControl;
    logic [7:0]   rdData;
    logic         rdValid;
    logic         irqOut;
    logic         timingInternal;
    logic         colorInvert;
    logic         autoScroll;
    logic         patternActive;
    logic         blankSuppress;
    logic         downstreamFlag;
    phase_t       phase;
  } state_t;
endpackage

// File: src/pattern_irq_regs.sv
// Pattern generator tail, indirect window and interrupt forwarding register bank
//
// How it works
// R1: With timing select set, the generator builds its own timing from its frame settings.
// R2: With timing select clear, the generator follows the external clock, enable and syncs.
// R3: The color invert bit makes the generator output inverted pattern colors.
// R4: Auto-scroll steps to the next enabled pattern after the frame-time count, else holds.
// R5: An 8-bit indirect address picks the indirect register; software writes it first.
// R6: Indirect data writes go to, and reads come from, the addressed indirect register.
// R7: The downstream enable bit lets a remote receiver interrupt through toward the output.
// R8: The global enable gates every interrupt onto the output; clear keeps it inactive.
// R9: A read-only status bit shows the remote receiver's downstream interrupt request.
// R10: A read-only global status bit is set while any enabled source is indicating.
// R11: By default pixel data present while the active video flag is low is forwarded.
// R12: The source should not send the mute pixel value into blanking.
// R13: With blanking suppression set, no video data is sent during blanking.
// R14: Patterns replace input video only while the pattern enable bit is set.
// R15: Reserved interrupt control and status bits read as zero and ignore writes.
`timescale 1ns/1ps
`include "pattern_irq_regs_defs.svh"

module pattern_irq_regs #(
  parameter int ADDR_W     = 8,
  parameter int DATA_W     = 8,
  parameter int IND_DEPTH  = 256
) (
  input  wire logic                ref_clk,
  input  wire logic                rst,
  input  wire logic                regWrite,
  input  wire logic                regRead,
  input  wire logic [ADDR_W-1:0]   regAddr,
  input  wire logic [DATA_W-1:0]   regWdata,
  output logic      [DATA_W-1:0]   regRdata,
  output logic                     regRdValid,
  input  wire logic                remoteIrq,
  output logic                     irqOut,
  output logic                     timingInternal,
  output logic                     colorInvert,
  output logic                     autoScroll,
  output logic                     patternActive,
  output logic                     blankSuppress
);
  pattern_irq_regs_pkg::state_t cur;
  pattern_irq_regs_pkg::state_t nxt;
  // Indirectly mapped generator registers live here; their meaning belongs to the generator
  logic [DATA_W-1:0] indirectMem [IND_DEPTH];
  logic [DATA_W-1:0] indirectRead;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  assign indirectRead = indirectMem[cur.indirectAddress];

  always_ff @(posedge ref_clk) begin
    if (regWrite && hit(regAddr, `OFS_PATTERN_IND_DATA)) begin
      indirectMem[cur.indirectAddress] <= regWdata; // R6
    end
  end

  always_comb begin
    logic         enabledAny;
    logic [7:0]   status;
    nxt        = cur;
    enabledAny = 1'b0;
    status     = 8'h00;
    nxt.downstreamFlag = remoteIrq; // R9
    enabledAny = cur.downstreamFlag & cur.interruptControl[`BIT_DOWNSTREAM_IRQ]; // R7
    status[`BIT_DOWNSTREAM_IRQ] = cur.downstreamFlag; // R9
    status[`BIT_GLOBAL_IRQ]     = enabledAny; // R10
    nxt.irqOut = enabledAny & cur.interruptControl[`BIT_GLOBAL_IRQ]; // R8
    nxt.rdValid = 1'b0;
    nxt.phase   = pattern_irq_regs_pkg::IDLE;
    if (regWrite) begin
      nxt.phase = pattern_irq_regs_pkg::WRITE_IND;
      case (regAddr)
        `OFS_GENERAL_CONFIG:    nxt.generalConfig   = regWdata;
        `OFS_PATTERN_CONTROL:   nxt.patternControl  = regWdata;
        `OFS_PATTERN_CONFIG:    nxt.patternConfig   = regWdata;
        `OFS_PATTERN_IND_ADDR:  nxt.indirectAddress = regWdata; // R5
        `OFS_INTERRUPT_CONTROL: nxt.interruptControl = regWdata & `MASK_INTERRUPT; // R15
        default:                nxt.phase = pattern_irq_regs_pkg::IDLE;
      endcase
    end else if (regRead) begin
      nxt.rdValid = 1'b1;
      nxt.phase   = pattern_irq_regs_pkg::READ_DONE;
      case (regAddr)
        `OFS_GENERAL_CONFIG:    nxt.rdData = cur.generalConfig;
        `OFS_PATTERN_CONTROL:   nxt.rdData = cur.patternControl;
        `OFS_PATTERN_CONFIG:    nxt.rdData = cur.patternConfig;
        `OFS_PATTERN_IND_ADDR:  nxt.rdData = cur.indirectAddress;
        `OFS_PATTERN_IND_DATA:  nxt.rdData = indirectRead; // R6
        `OFS_INTERRUPT_CONTROL: nxt.rdData = cur.interruptControl; // R15
        `OFS_INTERRUPT_STATUS:  nxt.rdData = status; // R15
        default:                nxt.rdData = 8'h00;
      endcase
    end
    // Decoded controls the pattern generator and link framer consume
    nxt.timingInternal = nxt.patternConfig[`BIT_TIMING_SELECT]; // R1 R2
    nxt.colorInvert    = nxt.patternConfig[`BIT_COLOR_INVERT]; // R3
    nxt.autoScroll     = nxt.patternConfig[`BIT_AUTO_SCROLL]; // R4
    nxt.patternActive  = nxt.patternControl[`BIT_PATTERN_ENABLE]; // R14
    // Default clear forwards blanking pixels; the source must then avoid the mute value
    nxt.blankSuppress  = nxt.generalConfig[`BIT_BLANK_SUPPRESS]; // R11 R13
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cur                  <= '0;
      cur.generalConfig    <= `RST_GENERAL_CONFIG;
      cur.patternControl   <= `RST_PATTERN_CONTROL;
      cur.patternConfig    <= `RST_PATTERN_CONFIG;
      cur.indirectAddress  <= `RST_PATTERN_IND_ADDR;
      cur.interruptControl <= `RST_INTERRUPT_CONTROL;
      cur.phase            <= pattern_irq_regs_pkg::IDLE;
    end else begin
      cur <= nxt;
    end
  end

  assign regRdata       = cur.rdData;
  assign regRdValid     = cur.rdValid;
  assign irqOut         = cur.irqOut;
  assign timingInternal = cur.timingInternal;
  assign colorInvert    = cur.colorInvert;
  assign autoScroll     = cur.autoScroll;
  assign patternActive  = cur.patternActive;
  assign blankSuppress  = cur.blankSuppress;
endmodule

// File: verification/pattern_irq_regs_assertions.sv
// Port-level assertions of the pattern and interrupt register bank
`timescale 1ns/1ps
module pattern_irq_regs_assertions #(parameter int ADDR_W = 8, parameter int DATA_W = 8) (
  input wire logic ref_clk, rst, regWrite, regRead, remoteIrq, regRdValid, irqOut,
  input wire logic timingInternal, colorInvert, autoScroll, patternActive, blankSuppress,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWdata, regRdata
);
  logic [1:0] ctl;
  logic       flg;
  wire logic  rdOk = regRead && !regWrite;
  wire logic  wrA = regWrite && regAddr == 8'h65;
  wire logic  irqWant = flg && ctl == 2'h3;
  wire logic [7:0] ctlImg = {2'h0, ctl[1], 4'h0, ctl[0]};
  wire logic [7:0] stsImg = {2'h0, flg, 4'h0, flg & ctl[1]};
  // Shadows of the live enables and the sampled remote level, so reads can be predicted
  always_ff @(posedge ref_clk)
    ctl <= rst ? 2'h0 : (regWrite && regAddr == 8'hC6) ? {regWdata[5], regWdata[0]} : ctl;
  always_ff @(posedge ref_clk)
    flg <= rst ? 1'b0 : remoteIrq;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_read_strobe: assert property (regRdValid == $past(rdOk)) else $error("bad strobe");
  a_irq_gate: assert property (irqOut == $past(irqWant)) else $error("bad irq");
  a_cfg_write: assert property (wrA |=> {timingInternal, colorInvert, autoScroll}
    == $past(regWdata[2:0])) else $error("bad cfg");
  a_cfg_hold: assert property (!wrA |=>
    $stable({timingInternal, colorInvert, autoScroll})) else $error("cfg moved");
  a_pattern_on: assert property (regWrite && regAddr == 8'h64 |=>
    patternActive == $past(regWdata[0])) else $error("bad enable");
  a_blank_supp: assert property (regWrite && regAddr == 8'h04 |=>
    blankSuppress == $past(regWdata[1])) else $error("bad suppress");
  a_ctl_read: assert property (rdOk && regAddr == 8'hC6 |=> regRdata == $past(ctlImg))
    else $error("bad ctl read");
  a_status_read: assert property (rdOk && regAddr == 8'hC7 |=> regRdata == $past(stsImg))
    else $error("bad status");
  c_irq: cover property (irqOut);
  c_status: cover property (rdOk && regAddr == 8'hC7 ##1 regRdata[5]);
  c_indirect: cover property (rdOk && regAddr == 8'h67);
endmodule
bind pattern_irq_regs pattern_irq_regs_assertions #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) chk (.*);

// File: verification/downstream_model.sv
// Downstream receiver that shows its interrupt request as a level
`timescale 1ns/1ps
module downstream_model (
  input  wire logic ref_clk,
  input  wire logic request,
  output logic      remoteIrq
);
  // Changes just after the edge, as a mirrored remote status line would
  // Only the interrupt level is modelled; pixel data, blanking and the mute value are not modelled
  initial remoteIrq = 1'b0;
  always @(posedge ref_clk) remoteIrq <= #1 request;
endmodule

// File: verification/pattern_irq_regs_bench.sv
// Self-checking bench of the pattern and interrupt register bank
`timescale 1ns/1ps
module pattern_irq_regs_bench;
  logic ref_clk = 1'b0, rst = 1'b1, regWrite = 1'b0, regRead = 1'b0, req = 1'b0;
  logic [7:0] regAddr = 8'h00, regWdata = 8'h00, regRdata;
  logic regRdValid, remoteIrq, irqOut, timingInternal, colorInvert, autoScroll;
  logic patternActive, blankSuppress;
  int err_total = 0, cmp_count = 0;
  logic [7:0] adr [7] = '{8'h04, 8'h64, 8'h65, 8'h66, 8'hC6, 8'hC7, 8'h3F};
  pattern_irq_regs dut (.*);
  downstream_model far (.ref_clk, .request(req), .remoteIrq);
  initial forever #12.5 ref_clk = ~ref_clk;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk) #1 {regWrite, regAddr, regWdata} = {1'b1, a, d};
    @(posedge ref_clk) #1 regWrite = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk) #1 {regRead, regAddr} = {1'b1, a};
    @(posedge ref_clk) #1 regRead = 1'b0;
    chk({7'h00, regRdValid}, 8'h01);
    chk(regRdata, exp);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Whole run is under a hundred cycles; this only trips on a hang
  initial begin
    #50000;
    err_total++;
    tally_and_finish();
  end
  initial begin
    repeat (4) @(posedge ref_clk);
    #1 rst = 1'b0;
    wr(8'h3F, 8'hFF);
    for (int i = 0; i < 7; i++) rd(adr[i], i == 1 ? 8'h10 : 8'h00);
    $display("test reset done");
    wr(8'h65, 8'h07);
    chk({5'h00, timingInternal, colorInvert, autoScroll}, 8'h07);
    wr(8'h65, 8'h02);
    chk({5'h00, timingInternal, colorInvert, autoScroll}, 8'h02);
    wr(8'h64, 8'h11);
    wr(8'h04, 8'h02);
    chk({6'h00, patternActive, blankSuppress}, 8'h03);
    wr(8'h64, 8'h10);
    wr(8'h04, 8'h00);
    chk({6'h00, patternActive, blankSuppress}, 8'h00);
    $display("test controls done");
    wr(8'h66, 8'hA5);
    wr(8'h67, 8'h3C);
    wr(8'h66, 8'h5A);
    wr(8'h67, 8'hC3);
    wr(8'h66, 8'hA5);
    rd(8'h67, 8'h3C);
    wr(8'h66, 8'h5A);
    rd(8'h67, 8'hC3);
    rd(8'h66, 8'h5A);
    $display("test indirect done");
    wr(8'hC6, 8'hFF);
    rd(8'hC6, 8'h21);
    req = 1'b1;
    repeat (4) @(posedge ref_clk);
    #1 chk({7'h00, irqOut}, 8'h01);
    rd(8'hC7, 8'h21);
    wr(8'hC6, 8'h20);
    @(posedge ref_clk) #1 chk({7'h00, irqOut}, 8'h00);
    rd(8'hC7, 8'h21);
    wr(8'hC6, 8'h01);
    rd(8'hC7, 8'h20);
    chk({7'h00, irqOut}, 8'h00);
    req = 1'b0;
    repeat (3) @(posedge ref_clk);
    rd(8'hC7, 8'h00);
    $display("test interrupt done");
    tally_and_finish();
  end
endmodule
